// ### ufte_pkg.sv
// shared constants, field positions and types of the uart fifo engine
package ufte_pkg;
  // ==========================================
  // timing
  localparam int CLK_HZ = 20_000_000; // system clock rate
  localparam int BAUD_BPS = 115_200; // line rate
  localparam int BAUD_DIV = CLK_HZ / BAUD_BPS; // clocks per bit
  localparam int FIFO_DEPTH = 4; // entries per fifo
  // ==========================================
  // register byte offsets
  localparam logic [7:0] A_DATA = 8'h00; // tx char write, rx char read
  localparam logic [7:0] A_FLAGS = 8'h04; // tx flags write, rx flags read
  localparam logic [7:0] A_GSR = 8'h08; // global status
  localparam logic [7:0] A_GER = 8'h0C; // global enable
  localparam logic [7:0] A_LCR = 8'h10; // line control
  localparam logic [7:0] A_FLVL = 8'h14; // fifo levels
  localparam logic [7:0] A_THR = 8'h18; // fifo thresholds
  localparam logic [7:0] A_RST = 8'h1C; // rx status, clear on read
  localparam logic [7:0] A_RIE = 8'h20; // rx status enables
  localparam logic [7:0] A_CCR = 8'h24; // control char recognition
  localparam logic [7:0] A_MATCH = 8'h28; // two match characters
  localparam logic [7:0] A_CMD = 8'h2C; // commands, write only
  localparam logic [7:0] A_IMD = 8'h30; // interrupt mode
  // ==========================================
  // field positions
  localparam int LCR_PEN = 0; // parity enable
  localparam int LCR_ODD = 1; // odd parity
  localparam int LCR_SWP = 2; // software parity
  localparam int LCR_BRK = 6; // send break
  localparam int G_RXF = 0; // rx fifo request
  localparam int G_TXF = 1; // tx fifo request
  localparam int G_RXM = 2; // rx machine request
  localparam int G_TXM = 4; // tx machine idle
  localparam int G_TMR = 5; // timer request
  localparam int G_SRC = 8; // winning source code, 3 bits
  localparam int F_OK = 0; // char received ok
  localparam int F_PAR = 1; // parity error
  localparam int F_FRM = 2; // framing error
  localparam int F_CTL = 3; // control character
  localparam int F_BRK = 4; // break character
  localparam int S_CTL = 1; // control char event
  localparam int S_BDET = 2; // break detected
  localparam int S_BTRM = 3; // break terminated
  localparam int S_PAR = 4; // parity error event
  localparam int S_FRM = 5; // framing error event
  localparam int S_OVR = 6; // overrun event
  localparam int C_EN = 0; // recognition on
  localparam int C_MAT = 1; // 1 match mode, 0 standard set
  localparam int C_EBC = 2; // ebcdic standard set
  localparam int K_STC = 0; // status clear command
  localparam int K_MACK = 1; // manual acknowledge command
  localparam int THR_RX = 4; // rx threshold field position
  localparam int LVL_RX = 4; // rx level field position
  // ==========================================
  // reset values
  localparam logic [7:0] RST_LCR = 8'h00;
  localparam logic [5:0] RST_GER = 6'h00;
  localparam logic [1:0] RST_THR = 2'h0;
  localparam logic [2:0] NO_SRC = 3'h7; // no source pending
  // ==========================================
  // types
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP, RX_BRK} ufte_rx_t;
  typedef struct packed {
    logic swpar; // software parity flag
    logic [7:0] data;
  } ufte_txent_t;
  typedef struct packed {
    logic [4:0] flags; // F_* positions
    logic [7:0] data;
  } ufte_rxent_t;
  typedef struct packed {
    logic ack; // wishbone ack
    logic [31:0] dat; // wishbone read data
    logic txd; // serial out
    logic irq; // interrupt out
    logic man; // manual ack latch
    logic [5:0] global_enable_reg;
    logic [7:0] line_control_reg;
    logic txflag; // stored sw parity flag
    logic [1:0] thr_tx;
    logic [1:0] thr_rx;
    logic [6:0] rstat;
    logic [6:0] rie;
    logic [2:0] control_char_recognition;
    logic [15:0] match;
    logic imd; // 1 manual ack mode
    logic tx_busy;
    logic [15:0] tx_div;
    logic [3:0] tx_left;
    logic [10:0] tx_sh;
    logic rx_s1; // synchroniser stage 1
    logic rx_s2; // synchroniser stage 2
    ufte_rx_t rx_st;
    logic [15:0] rx_div;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic brk_on; // break in progress
  } ufte_st_t;
endpackage

// ### ufte_fifo.sv
// small synchronous fifo with show-ahead read
module ufte_fifo #(
  parameter int W = 8,
  parameter int D = 4,
  parameter int LW = $clog2(D + 1)
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic push_i,
  input wire logic [W-1:0] data_i,
  input wire logic pop_i,
  output logic [W-1:0] data_o,
  output logic full_o,
  output logic empty_o,
  output logic [LW-1:0] level_o
);
  localparam int AW = $clog2(D); // D is a power of two
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [LW-1:0] cnt;
  } ufte_fifo_st_t;
  ufte_fifo_st_t q, d;
  logic pu, po;
  // ==========================================
  // next state: a push into a full fifo is dropped
  always_comb begin
    d = q;
    pu = push_i & (q.cnt != LW'(D));
    po = pop_i & (q.cnt != '0);
    if (pu) begin
      d.mem[q.wp] = data_i;
      d.wp = q.wp + 1'b1;
    end
    if (po) begin
      d.rp = q.rp + 1'b1;
    end
    d.cnt = q.cnt + LW'(pu) - LW'(po);
  end
  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else if (ce_i) begin
      q <= d;
    end
  end
  assign data_o = q.mem[q.rp];
  assign full_o = (q.cnt == LW'(D));
  assign empty_o = (q.cnt == '0);
  assign level_o = q.cnt;
endmodule

// ### ufte_core.sv
// uart transmit and receive engine with fifos, flags and interrupt
// Summary of operation
// - host tx write pushes char with flags
// - idle shifter loads next char, sends serially
// - flags sent only as configured parity
// - tx fifo holds four, five when idle
// - timer first, tx machine second priority
// - tx idle request cleared only by tx write or enable
// - tx request on threshold or transmitter empty
// - status shows tx fifo and idle bits
// - line control bit six forces break level
// - break mid char: line low, chars lost
// - rx request while level above threshold
// - per char integrity flags stored with char
// - rx status accumulates events since read
// - rx read presents next char and flags
// - rx machine errors and events raise requests
// - level register reports rx fifo level
// - standard set or two match characters
// - control char sets event and flag
// - tx request while level at or below threshold
// - manual mode: interrupt only on acknowledge
//
// The placing of the registers and register access over Wishbone were chosen for this implementation.
module ufte_core #(
  parameter int BAUD_DIV = ufte_pkg::BAUD_DIV,
  parameter int DEPTH = ufte_pkg::FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic rxd_i,
  input wire logic timer_req_i,
  output logic txd_o,
  output logic int_o
);
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [15:0] DIV_M1 = 16'(BAUD_DIV - 1); // full bit
  localparam logic [15:0] DIV_H = 16'(BAUD_DIV / 2); // half bit

  ufte_pkg::ufte_st_t q, d; // all state
  // ==========================================
  // fifo connections
  logic tx_push, tx_pop, tx_full, tx_empty;
  logic rx_push, rx_pop, rx_full, rx_empty;
  ufte_pkg::ufte_txent_t tx_wd, tx_rd;
  ufte_pkg::ufte_rxent_t rx_wd, rx_rd;
  logic [LW-1:0] tx_lvl, rx_lvl;
  // ==========================================
  // decoded requests
  logic acc, wr, rd; // bus access this cycle
  logic txm_idle, tx_req, rx_req, rxm_req;
  logic [5:0] pend; // enabled pending sources
  logic [2:0] src; // winning source
  logic [4:0] fl; // flags of finished char
  logic [6:0] ev; // rx events this cycle
  logic par_calc;

  // standard or matched control character test
  function automatic logic is_ctrl(input logic [7:0] c, input logic [2:0] cfg,
                                   input logic [15:0] m);
    logic r;
    r = 1'b0;
    if (cfg[ufte_pkg::C_MAT]) begin
      r = (c == m[7:0]) || (c == m[15:8]);
    end else if (cfg[ufte_pkg::C_EBC]) begin
      r = (c < 8'h40) || (c == 8'hFF);
    end else begin
      r = (c < 8'h20) || (c == 8'h7F);
    end
    return r & cfg[ufte_pkg::C_EN];
  endfunction

  // ==========================================
  // fifos
  ufte_fifo #(.W($bits(ufte_pkg::ufte_txent_t)), .D(DEPTH)) u_txf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(tx_push),
    .data_i(tx_wd),
    .pop_i(tx_pop),
    .data_o(tx_rd),
    .full_o(tx_full),
    .empty_o(tx_empty),
    .level_o(tx_lvl)
  );
  ufte_fifo #(.W($bits(ufte_pkg::ufte_rxent_t)), .D(DEPTH)) u_rxf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .push_i(rx_push),
    .data_i(rx_wd),
    .pop_i(rx_pop),
    .data_o(rx_rd),
    .full_o(rx_full),
    .empty_o(rx_empty),
    .level_o(rx_lvl)
  );

  // ==========================================
  // request decode
  assign acc = wb_cyc_i & wb_stb_i & ~q.ack; // one ack per access
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  // shifter empty takes the fifo head at once
  assign tx_pop = ~q.tx_busy & ~tx_empty;
  assign tx_push = wr & (wb_adr_i == ufte_pkg::A_DATA) & ~tx_full;
  assign tx_wd = '{swpar: q.txflag, data: wb_dat_i[7:0]};
  assign rx_pop = rd & (wb_adr_i == ufte_pkg::A_DATA) & ~rx_empty;
  assign txm_idle = ~q.tx_busy & tx_empty;
  assign tx_req = (tx_lvl <= LW'(q.thr_tx));
  assign rx_req = (rx_lvl > LW'(q.thr_rx));
  assign rxm_req = |(q.rstat & q.rie);
  // parity of the received char, for checking
  assign par_calc = (^q.rx_sh) ^ q.line_control_reg[ufte_pkg::LCR_ODD];

  // gate sources with the global enables
  always_comb begin
    pend = '0;
    pend[ufte_pkg::G_TMR] = timer_req_i & q.global_enable_reg[ufte_pkg::G_TMR];
    pend[ufte_pkg::G_TXM] = txm_idle & q.global_enable_reg[ufte_pkg::G_TXM];
    pend[ufte_pkg::G_RXM] = rxm_req & q.global_enable_reg[ufte_pkg::G_RXM];
    pend[ufte_pkg::G_RXF] = rx_req & q.global_enable_reg[ufte_pkg::G_RXF];
    pend[ufte_pkg::G_TXF] = tx_req & q.global_enable_reg[ufte_pkg::G_TXF];
  end

  // fixed priority: nothing below tx machine wins while it pends
  always_comb begin
    if (pend[ufte_pkg::G_TMR]) begin
      src = 3'(ufte_pkg::G_TMR);
    end else if (pend[ufte_pkg::G_TXM]) begin
      src = 3'(ufte_pkg::G_TXM);
    end else if (pend[ufte_pkg::G_RXM]) begin
      src = 3'(ufte_pkg::G_RXM);
    end else if (pend[ufte_pkg::G_RXF]) begin
      src = 3'(ufte_pkg::G_RXF);
    end else if (pend[ufte_pkg::G_TXF]) begin
      src = 3'(ufte_pkg::G_TXF);
    end else begin
      src = ufte_pkg::NO_SRC;
    end
  end

  // ==========================================
  // next state
  always_comb begin
    d = q;
    rx_push = 1'b0;
    rx_wd = '0;
    fl = '0;
    ev = '0;
    d.ack = acc;
    // ---- register writes
    if (wr) begin
      unique case (wb_adr_i)
        ufte_pkg::A_FLAGS: d.txflag = wb_dat_i[0];
        ufte_pkg::A_GER: d.global_enable_reg = wb_dat_i[5:0];
        ufte_pkg::A_LCR: d.line_control_reg = wb_dat_i[7:0];
        ufte_pkg::A_THR: begin
          d.thr_tx = wb_dat_i[1:0];
          d.thr_rx = wb_dat_i[ufte_pkg::THR_RX+:2];
        end
        ufte_pkg::A_RIE: d.rie = wb_dat_i[6:0];
        ufte_pkg::A_CCR: d.control_char_recognition = wb_dat_i[2:0];
        ufte_pkg::A_MATCH: d.match[7:0] = wb_dat_i[7:0];
        ufte_pkg::A_IMD: d.imd = wb_dat_i[0];
        default: ; // data, commands and read-only offsets
      endcase
    end
    if (wr && wb_sel_i[1] && wb_adr_i == ufte_pkg::A_MATCH) begin
      d.match[15:8] = wb_dat_i[15:8];
    end
    // ---- rx status: cleared by its read or status clear
    if (rd && wb_adr_i == ufte_pkg::A_RST) begin
      d.rstat = '0;
    end
    if (wr && wb_adr_i == ufte_pkg::A_CMD && wb_dat_i[ufte_pkg::K_STC]) begin
      d.rstat = '0;
    end
    // ---- register reads, unmapped reads as zero
    d.dat = '0;
    if (rd) begin
      unique case (wb_adr_i)
        ufte_pkg::A_DATA: d.dat[7:0] = rx_rd.data;
        ufte_pkg::A_FLAGS: d.dat[4:0] = rx_rd.flags;
        ufte_pkg::A_GSR: begin
          d.dat[ufte_pkg::G_RXF] = rx_req;
          d.dat[ufte_pkg::G_TXF] = tx_req;
          d.dat[ufte_pkg::G_RXM] = rxm_req;
          d.dat[ufte_pkg::G_TXM] = txm_idle;
          d.dat[ufte_pkg::G_TMR] = timer_req_i;
          d.dat[ufte_pkg::G_SRC+:3] = src;
        end
        ufte_pkg::A_GER: d.dat[5:0] = q.global_enable_reg;
        ufte_pkg::A_LCR: d.dat[7:0] = q.line_control_reg;
        ufte_pkg::A_FLVL: begin
          d.dat[2:0] = 3'(tx_lvl);
          d.dat[ufte_pkg::LVL_RX+:3] = 3'(rx_lvl);
        end
        ufte_pkg::A_THR: begin
          d.dat[1:0] = q.thr_tx;
          d.dat[ufte_pkg::THR_RX+:2] = q.thr_rx;
        end
        ufte_pkg::A_RST: d.dat[6:0] = q.rstat;
        ufte_pkg::A_RIE: d.dat[6:0] = q.rie;
        ufte_pkg::A_CCR: d.dat[2:0] = q.control_char_recognition;
        ufte_pkg::A_MATCH: d.dat[15:0] = q.match;
        ufte_pkg::A_IMD: d.dat[0] = q.imd;
        default: d.dat = '0;
      endcase
    end
    // ---- transmitter
    if (tx_pop) begin
      d.tx_busy = 1'b1;
      d.tx_div = DIV_M1;
      if (q.line_control_reg[ufte_pkg::LCR_PEN]) begin
        // sw parity sends the stored flag, else computed parity
        d.tx_sh = {1'b1, q.line_control_reg[ufte_pkg::LCR_SWP] ? tx_rd.swpar :
                   (^tx_rd.data) ^ q.line_control_reg[ufte_pkg::LCR_ODD], tx_rd.data, 1'b0};
        d.tx_left = 4'hB;
      end else begin
        d.tx_sh = {2'b11, tx_rd.data, 1'b0};
        d.tx_left = 4'hA;
      end
    end else if (q.tx_busy) begin
      // shifting goes on under break, so the char is lost
      if (q.tx_div == '0) begin
        d.tx_div = DIV_M1;
        d.tx_sh = {1'b1, q.tx_sh[10:1]};
        d.tx_left = q.tx_left - 1'b1;
        d.tx_busy = (q.tx_left != 4'h1);
      end else begin
        d.tx_div = q.tx_div - 1'b1;
      end
    end
    // break overrides the shifter at once
    d.txd = q.line_control_reg[ufte_pkg::LCR_BRK] ? 1'b0 : (~q.tx_busy | q.tx_sh[0]);
    // ---- receiver: two-stage synchroniser
    d.rx_s1 = rxd_i;
    d.rx_s2 = q.rx_s1;
    if (q.rx_st != ufte_pkg::RX_IDLE && q.rx_st != ufte_pkg::RX_BRK) begin
      d.rx_div = (q.rx_div == '0) ? DIV_M1 : q.rx_div - 1'b1;
    end
    unique case (q.rx_st)
      ufte_pkg::RX_IDLE: begin
        if (!q.rx_s2) begin
          d.rx_st = ufte_pkg::RX_START;
          d.rx_div = DIV_H;
        end
      end
      ufte_pkg::RX_START: begin
        // a start bit gone by mid bit was a glitch
        if (q.rx_div == '0) begin
          d.rx_st = q.rx_s2 ? ufte_pkg::RX_IDLE : ufte_pkg::RX_DATA;
          d.rx_bit = '0;
        end
      end
      ufte_pkg::RX_DATA: begin
        if (q.rx_div == '0) begin
          d.rx_sh = {q.rx_s2, q.rx_sh[7:1]};
          d.rx_bit = q.rx_bit + 1'b1;
          if (q.rx_bit == 3'h7) begin
            d.rx_st = q.line_control_reg[ufte_pkg::LCR_PEN] ? ufte_pkg::RX_PAR : ufte_pkg::RX_STOP;
          end
        end
      end
      ufte_pkg::RX_PAR: begin
        if (q.rx_div == '0) begin
          d.rx_par = q.rx_s2;
          d.rx_st = ufte_pkg::RX_STOP;
        end
      end
      ufte_pkg::RX_STOP: begin
        if (q.rx_div == '0) begin
          fl[ufte_pkg::F_FRM] = ~q.rx_s2;
          fl[ufte_pkg::F_PAR] = q.line_control_reg[ufte_pkg::LCR_PEN] & ~q.line_control_reg[ufte_pkg::LCR_SWP]
                                & (q.rx_par != par_calc);
          fl[ufte_pkg::F_BRK] = ~q.rx_s2 & (q.rx_sh == '0)
                                & ~(q.line_control_reg[ufte_pkg::LCR_PEN] & q.rx_par);
          fl[ufte_pkg::F_CTL] = is_ctrl(q.rx_sh, q.control_char_recognition, q.match);
          // a control character is still a good character
          fl[ufte_pkg::F_OK] = ~(fl[ufte_pkg::F_PAR] | fl[ufte_pkg::F_FRM]
                                 | fl[ufte_pkg::F_BRK]);
          ev[ufte_pkg::S_CTL] = fl[ufte_pkg::F_CTL];
          ev[ufte_pkg::S_PAR] = fl[ufte_pkg::F_PAR];
          ev[ufte_pkg::S_FRM] = fl[ufte_pkg::F_FRM];
          ev[ufte_pkg::S_BDET] = fl[ufte_pkg::F_BRK];
          ev[ufte_pkg::S_OVR] = rx_full;
          // a full fifo keeps its contents; the new char is lost
          rx_push = ~rx_full;
          rx_wd = '{flags: fl, data: q.rx_sh};
          d.brk_on = fl[ufte_pkg::F_BRK];
          d.rx_st = q.rx_s2 ? ufte_pkg::RX_IDLE : ufte_pkg::RX_BRK;
        end
      end
      ufte_pkg::RX_BRK: begin
        // wait for mark; ending a break is an event of its own
        if (q.rx_s2) begin
          ev[ufte_pkg::S_BTRM] = q.brk_on;
          d.brk_on = 1'b0;
          d.rx_st = ufte_pkg::RX_IDLE;
        end
      end
      default: d.rx_st = ufte_pkg::RX_IDLE;
    endcase
    // events set after any clear, so a same-cycle event survives
    d.rstat = d.rstat | ev;
    // ---- interrupt output
    if (!(|pend)) begin
      d.man = 1'b0;
    end else if (wr && wb_adr_i == ufte_pkg::A_CMD && wb_dat_i[ufte_pkg::K_MACK]) begin
      d.man = 1'b1;
    end
    d.irq = q.imd ? d.man : |pend;
  end

  // ==========================================
  // state register, frozen while ce_i is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.txd <= 1'b1;
      q.line_control_reg <= ufte_pkg::RST_LCR;
      q.global_enable_reg <= ufte_pkg::RST_GER;
      q.thr_tx <= ufte_pkg::RST_THR;
      q.thr_rx <= ufte_pkg::RST_THR;
      q.rx_s1 <= 1'b1;
      q.rx_s2 <= 1'b1;
      q.rx_st <= ufte_pkg::RX_IDLE;
    end else if (ce_i) begin
      q <= d;
    end
  end
  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign txd_o = q.txd;
  assign int_o = q.irq;

  // ==========================================
  // checks
  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (rst_i);
  sequence s_load;
    tx_pop && !q.line_control_reg[ufte_pkg::LCR_BRK];
  endsequence
  sequence s_start;
    !q.line_control_reg[ufte_pkg::LCR_BRK] ##1 !txd_o;
  endsequence
  chk_tx_start_bit: assert property (s_load |=> s_start)
    else $error("start bit not sent after load");
  chk_break_level: assert property (q.line_control_reg[ufte_pkg::LCR_BRK] |=> !txd_o)
    else $error("break did not force line low");
  chk_full_drop: assert property (tx_full && !tx_pop |=> tx_full && $stable(tx_lvl))
    else $error("full tx fifo changed level");
  chk_tx_push_lvl: assert property (tx_push && !tx_pop |=> tx_lvl == $past(tx_lvl) + 1'b1)
    else $error("tx write did not enter fifo");
  chk_rx_req_rise: assert property (rx_push && !rx_pop && rx_lvl == LW'(q.thr_rx)
                                    |=> rx_req)
    else $error("rx request missing above threshold");
  chk_rx_read_next: assert property (rx_pop && !rx_push |=> rx_lvl == $past(rx_lvl) - 1'b1)
    else $error("rx read did not advance fifo");
  chk_txm_persist: assert property (pend[ufte_pkg::G_TXM] && !tx_push
                                    |=> pend[ufte_pkg::G_TXM] || !q.global_enable_reg[ufte_pkg::G_TXM])
    else $error("tx idle request dropped alone");
  chk_txm_priority: assert property (pend[ufte_pkg::G_TXM] && !pend[ufte_pkg::G_TMR]
                                     |-> src == 3'(ufte_pkg::G_TXM))
    else $error("lower source beat tx machine");
  chk_manual_hold: assert property (q.imd && !q.man |=> ##1 !int_o || q.man)
    else $error("interrupt without manual ack");
  chk_status_sticky: assert property (ev[ufte_pkg::S_OVR] |=> q.rstat[ufte_pkg::S_OVR])
    else $error("rx event lost");
endmodule

// ### ufte_station.sv
// remote serial station model: captures txd frames, sends rxd frames
module ufte_station #(
  parameter int DIV = 8
) (
  input wire logic clk_i,
  input wire logic txd_i,
  output logic rxd_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got_q[$]; // captured frames, oldest first
  int nbits = 8; // data bits plus optional parity
  logic [8:0] r; // frame being collected
  initial rxd_o = 1'h1; // mark level while idle
  // ==========
  // receiver
  // centre on the start bit, then one sample per bit time
  always begin
    @(negedge txd_i);
    repeat (DIV / 2) @(posedge clk_i);
    r = '0;
    for (int i = 0; i < nbits; i++) begin
      repeat (DIV) @(posedge clk_i);
      r[i] = txd_i; // lsb first
    end
    repeat (DIV) @(posedge clk_i); // stop bit, not judged
    got_q.push_back(r);
  end
  // ==========
  // sender
  // start, eight bits lsb first, stop; a frame is never cut short
  task automatic send(input logic [7:0] c);
    logic [9:0] f;
    f = {1'h1, c, 1'h0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (DIV - 1) @(posedge clk_i);
    end
  endtask
endmodule

// ### tb.sv
// self-checking bench of the uart fifo engine
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DIV = 8; // short bit time keeps the run brief
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic we = 1'h0;
  logic cyc = 1'h0;
  logic stb = 1'h0;
  logic tmr = 1'h0; // timer request level
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] q; // last read data
  logic [31:0] rdat;
  logic txd, intr, ack, rxd;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  ufte_core #(.BAUD_DIV(DIV)) i_ufte_core (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'h1),
    .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(rxd), .timer_req_i(tmr),
    .txd_o(txd), .int_o(intr));
  ufte_station #(.DIV(DIV)) i_ufte_station (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
  // ==========
  // clock and watchdog
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  initial begin
    #1_000_000; // about seventeen times the expected run
    n_mismatch++;
    end_sim();
  end
  // ==========
  // tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
    end
  endtask
  // one classic cycle; held until ack is sampled, then released
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    // no cycle count is assumed: the watchdog ends a hang
    do begin
      @(posedge clk_i);
    end while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'h1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(a, 1'h0, 32'h0);
  endtask
  task automatic ticks(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  task automatic end_sim;
    $display("mismatches %0d, comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // ==========
  // tests
  initial begin
    ticks(10);
    rst_i <= 1'h0;
    ticks(1);
    rd(ufte_pkg::A_GSR);
    chk(q & 32'h1F, 32'h12);
    // burst of six into an idle transmitter: one too many
    for (int i = 0; i < 6; i++) wr(ufte_pkg::A_DATA, 32'h30 + i);
    rd(ufte_pkg::A_FLVL);
    chk(q & 32'h7, 32'h4);
    rd(ufte_pkg::A_GSR);
    chk(q & 32'h12, 32'h0);
    ticks(600);
    chk(i_ufte_station.got_q.size(), 5);
    for (int i = 0; i < 5; i++) chk(i_ufte_station.got_q[i], 32'h30 + i);
    i_ufte_station.got_q.delete();
    // stored flag goes out as the parity bit
    i_ufte_station.nbits = 9;
    wr(ufte_pkg::A_LCR, 32'h5);
    wr(ufte_pkg::A_FLAGS, 32'h1);
    wr(ufte_pkg::A_DATA, 32'h5A);
    ticks(120);
    chk(i_ufte_station.got_q[0], 32'h15A);
    i_ufte_station.nbits = 8;
    wr(ufte_pkg::A_LCR, 32'h0);
    // priority, persistence and manual acknowledge
    wr(ufte_pkg::A_GER, 32'h30);
    tmr <= 1'h1;
    ticks(3);
    rd(ufte_pkg::A_GSR);
    chk(q, 32'h532);
    chk(intr, 32'h1);
    tmr <= 1'h0;
    ticks(20);
    rd(ufte_pkg::A_GSR);
    chk(q, 32'h412);
    wr(ufte_pkg::A_GER, 32'h0);
    ticks(3);
    chk(intr, 32'h0);
    wr(ufte_pkg::A_IMD, 32'h1);
    wr(ufte_pkg::A_GER, 32'h10);
    ticks(3);
    chk(intr, 32'h0);
    wr(ufte_pkg::A_CMD, 32'h2);
    ticks(3);
    chk(intr, 32'h1);
    wr(ufte_pkg::A_GER, 32'h0);
    wr(ufte_pkg::A_IMD, 32'h0);
    // break only once the transmitter is idle
    rd(ufte_pkg::A_GSR);
    chk(q & 32'h10, 32'h10);
    wr(ufte_pkg::A_LCR, 32'h40);
    ticks(2);
    n = 0;
    repeat (100) begin
      @(posedge clk_i);
      n += (txd === 1'h0);
    end
    chk(n, 100);
    wr(ufte_pkg::A_LCR, 32'h0);
    ticks(2);
    chk(txd, 32'h1);
    // reception with ascii control recognition
    wr(ufte_pkg::A_CCR, 32'h1);
    i_ufte_station.send(8'h41);
    i_ufte_station.send(8'h03);
    ticks(8);
    rd(ufte_pkg::A_FLVL);
    chk(q, 32'h20);
    rd(ufte_pkg::A_GSR);
    chk(q & 32'h1, 32'h1);
    rd(ufte_pkg::A_FLAGS);
    chk(q, 32'h1);
    rd(ufte_pkg::A_DATA);
    chk(q, 32'h41);
    rd(ufte_pkg::A_FLAGS);
    chk(q, 32'h9);
    rd(ufte_pkg::A_DATA);
    chk(q, 32'h3);
    rd(ufte_pkg::A_RST);
    chk(q, 32'h2);
    rd(ufte_pkg::A_RST);
    chk(q, 32'h0);
    end_sim();
  end
endmodule
